/* dv/adc_scan_properties.sv */
`timescale 1ns/100ps
module adc_scan_properties
    import adc_scan_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        nrst,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [3:0]  analog_input_select,
    input wire logic        dma_request,
    input wire logic        dma_ack,
    input wire logic [9:0]  conversion_result
);
    logic [3:0] start_reg;
    logic [7:0] top_reg;
    logic       cor_reg;
    wire        wc = avs_write && !avs_waitrequest && avs_address == 4'h0;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            start_reg <= 4'h0;
            top_reg   <= 8'h00;
            cor_reg   <= 1'b0;
        end
        else if (avs_write && !avs_waitrequest)
        begin
            if (avs_address == 4'h0)
            begin
                start_reg <= avs_writedata[3:0];
                cor_reg   <= avs_writedata[6];
            end
            if (avs_address == 4'h4)
                top_reg <= avs_writedata[7:0];
        end
    end
////////////////////////////////////////////////////////////////////////
    a_wait_first: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest)
        else $error("no wait cycle");
    a_answer_next: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("answer late");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    a_top_readback: assert property (avs_read && !avs_waitrequest && avs_address == 4'h4
        |-> avs_readdata == {24'h0, top_reg}) else $error("top readback");
    a_step_reload: assert property ($changed(analog_input_select) && !$past(wc)
        |-> ({4'h0, $past(analog_input_select)} >= top_reg) ? analog_input_select == start_reg
        : analog_input_select == $past(analog_input_select) + 4'h1) else $error("bad channel step");
    a_limit_cap: assert property ($changed(analog_input_select) && !$past(wc) && start_reg <= top_reg
        |-> {4'h0, analog_input_select} <= top_reg) else $error("channel above top");
    a_req_cor: assert property ($rose(dma_request) |-> cor_reg)
        else $error("request without mode");
    a_ack_clears: assert property (dma_ack && dma_request |=> !dma_request)
        else $error("ack not clearing");
    a_result_hold: assert property (dma_request && $past(dma_request) |-> $stable(conversion_result))
        else $error("result moved");
    a_keeps_going: assert property (dma_ack && dma_request && cor_reg |-> ##[10:40] dma_request)
        else $error("scan stalled");
    c_result: cover property ($rose(dma_request));
    c_reload: cover property ($changed(analog_input_select) && !$past(wc) && analog_input_select == start_reg);
    c_unmapped: cover property (avs_read && !avs_waitrequest && avs_address == 4'h1);
endmodule
bind adc_scan_convert_on_read adc_scan_properties u_props (.core_clk, .nrst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .analog_input_select, .dma_request,
    .dma_ack, .conversion_result);

/* dv/dma_model.sv */
`timescale 1ns/100ps
module dma_model
(
    input wire logic       core_clk,
    input wire logic       nrst,
    input wire logic       dma_request,
    input wire logic [7:0] stall,
    output logic           dma_ack
);
    logic [7:0] wait_reg;
    logic [7:0] wait_next;
    logic       ack_next;
    always_comb
    begin
        wait_next = 8'h00;
        ack_next  = 1'b0;
        if (dma_request && !dma_ack)
        begin
            if (wait_reg >= stall)
                ack_next = 1'b1;
            else
                wait_next = wait_reg + 8'h01;
        end
    end
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wait_reg <= 8'h00;
            dma_ack  <= 1'b0;
        end
        else
        begin
            wait_reg <= wait_next;
            dma_ack  <= ack_next;
        end
    end
endmodule

/* dv/testbench.sv */
`timescale 1ns/100ps
module testbench
    import adc_scan_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        nrst = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [9:0]  analog_sample;
    logic [3:0]  analog_input_select;
    logic [3:0]  chan_exp;
    logic        dma_request;
    logic        dma_ack;
    logic [9:0]  conversion_result;
    logic [7:0]  stall = 8'h00;
    int          error_cnt = 0;
    int          check_count = 0;
    always #12.5 core_clk = ~core_clk;
    adc_scan_convert_on_read u_dut (.core_clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .analog_sample, .analog_input_select, .dma_request, .dma_ack,
        .conversion_result);
    dma_model u_dma (.core_clk, .nrst, .dma_request, .stall, .dma_ack);
    // Sample carries its channel, so a result shows which input it came from
    always @(posedge core_clk)
        analog_sample <= {6'h29, analog_input_select};
////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        if (error_cnt == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic write_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        @(posedge core_clk iff !avs_waitrequest);
        avs_write <= 1'b0;
    endtask
    task automatic read_reg(input logic [3:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        avs_address <= a;
        avs_read <= 1'b1;
        @(posedge core_clk iff !avs_waitrequest);
        chk(avs_readdata, exp);
        avs_read <= 1'b0;
    endtask
    // Channel is sampled while the result is pending, so it already shows the next step
    task automatic scan(input int n, input logic [3:0] lo, input logic [3:0] hi);
        logic [3:0] conv_chan;
        repeat (n)
        begin
            conv_chan = chan_exp;
            chan_exp = (chan_exp >= hi) ? lo : chan_exp + 4'h1;
            @(posedge core_clk iff dma_request);
            chk({28'h0, analog_input_select}, {28'h0, chan_exp});
            chk({22'h0, conversion_result}, {22'h0, 6'h29, conv_chan});
            @(posedge core_clk iff !dma_request);
        end
    endtask
////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        read_reg(4'h0, 32'h0);
        read_reg(4'h4, 32'h0);
        write_reg(4'h1, 32'hff);
        read_reg(4'h1, 32'h0);
        write_reg(4'h4, 32'h5);
        read_reg(4'h4, 32'h5);
        chan_exp = 4'h3;
        write_reg(4'h0, 32'hc3);
        scan(7, 4'h3, 4'h5);
        stall <= 8'd12;
        scan(3, 4'h3, 4'h5);
        // Reconfigure only while a result waits, so no conversion ends mid-write
        stall <= 8'd200;
        @(posedge core_clk iff dma_request);
        read_reg(4'h8, 32'h294);
        read_reg(4'hc, 32'h4);
        write_reg(4'h4, 32'h7);
        write_reg(4'h0, 32'hc7);
        chan_exp = 4'h7;
        stall <= 8'h00;
        // Let the result from the old range drain first
        @(posedge core_clk iff !dma_request);
        scan(4, 4'h7, 4'h7);
        stall <= 8'd200;
        @(posedge core_clk iff dma_request);
        write_reg(4'h0, 32'h00);
        repeat (3) @(posedge core_clk);
        chk({31'h0, dma_request}, 32'h0);
        // Without convert-on-read: one conversion, enable clears, no request
        write_reg(4'h0, 32'h82);
        repeat (30) @(posedge core_clk);
        read_reg(4'h0, 32'h2);
        read_reg(4'h8, 32'h292);
        chk({31'h0, dma_request}, 32'h0);
        complete_run();
    end
    initial
    begin
        repeat (8000) @(posedge core_clk);
        error_cnt++;
        complete_run();
    end
endmodule

/* hw/adc_scan_convert_on_read.sv */
`timescale 1ns/100ps
`include "adc_scan_params.svh"
module adc_scan_convert_on_read
    import adc_scan_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [9:0]  analog_sample,
    output logic [3:0]       analog_input_select,
    output logic             dma_request,
    input  wire logic        dma_ack,
    output logic [9:0]       conversion_result
);
    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic [7:0]     converter_control_reg;
    logic [7:0]     converter_control_next;
    logic [7:0]     top_channel_limit_reg;
    logic [7:0]     top_channel_limit_next;
    logic [3:0]     start_channel_reg;
    logic [3:0]     start_channel_next;
    logic [9:0]     result_reg;
    logic [9:0]     result_next;
    logic           result_valid_reg;
    logic           result_valid_next;
    logic           ack_reg;
    logic           ack_next;
    logic [31:0]    readdata_reg;
    logic [31:0]    readdata_next;
    scan_state_type state_reg;
    scan_state_type state_next;
    logic           conv_start;
    logic           conv_busy;
    logic           conv_done;
    logic [3:0]     chan;
    logic           enabled;
    logic           cor_mode;
    logic [9:0]     sample_meta_reg;
    logic [9:0]     sample_sync_reg;

    assign chan     = converter_control_reg[`CTRL_CHAN_MSB:0];
    assign enabled  = converter_control_reg[`CTRL_ENABLE_BIT];
    assign cor_mode = converter_control_reg[`CTRL_COR_BIT];

    // Analog core output is foreign to this clock
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sample_meta_reg <= 10'h000;
            sample_sync_reg <= 10'h000;
        end
        else
        begin
            sample_meta_reg <= analog_sample;
            sample_sync_reg <= sample_meta_reg;
        end
    end

    conv_timer u_timer
    (
        .core_clk (core_clk),
        .nrst     (nrst),
        .start    (conv_start),
        .busy     (conv_busy),
        .done     (conv_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencer and registers
    always_comb
    begin
        converter_control_next = converter_control_reg;
        top_channel_limit_next = top_channel_limit_reg;
        start_channel_next     = start_channel_reg;
        result_next            = result_reg;
        result_valid_next      = result_valid_reg;
        state_next             = state_reg;
        conv_start             = 1'b0;
        ack_next               = 1'b0;
        readdata_next          = readdata_reg;

        // One wait cycle per access: read data fetched on the first cycle, answered next
        if ((avs_read || avs_write) && !ack_reg)
        begin
            ack_next = 1'b1;
            if (avs_read)
            begin
                case (avs_address)
                    `CTRL_OFFSET:   readdata_next = {24'h000000, converter_control_reg};
                    `TOP_OFFSET:    readdata_next = {24'h000000, top_channel_limit_reg};
                    `RESULT_OFFSET: readdata_next = {22'h000000, result_reg};
                    // Bit 1 reserved, reads as zero
                    `STATUS_OFFSET: readdata_next = {28'h0000000, state_reg == st_convert, result_valid_reg,
                                                     1'b0, conv_busy};
                    default:        readdata_next = `ZERO_WORD;
                endcase
            end
        end

        // A write lands only on the edge that sees waitrequest low, as the master expects
        if (avs_write && ack_reg)
        begin
            case (avs_address)
                `CTRL_OFFSET:
                begin
                    converter_control_next = avs_writedata[7:0];
                    // Latch the start channel as software sets it
                    start_channel_next = avs_writedata[`CTRL_CHAN_MSB:0]; // see [RL7]
                end
                `TOP_OFFSET: top_channel_limit_next = avs_writedata[7:0];
                default: ;
            endcase
        end

        // Limitation: a scan step in the same cycle overrides a channel write

        // A DMA take frees the result slot; a new result written later wins
        if (dma_ack)
            result_valid_next = 1'b0; // see [RL1]

        case (state_reg)
            st_idle:
            begin
                if (enabled)
                begin
                    conv_start = 1'b1;
                    state_next = st_convert;
                end
            end
            st_convert:
            begin
                if (conv_done)
                begin
                    result_next       = sample_sync_reg;
                    result_valid_next = 1'b1; // see [RL1]
                    if (cor_mode)
                    begin
                        // Limit compares in full width; channel field can still exceed it when the start channel is above it
                        if ({4'h0, chan} >= top_channel_limit_reg) // see [RL4]
                            converter_control_next[`CTRL_CHAN_MSB:0] = start_channel_reg; // see [RL3]
                        else
                            converter_control_next[`CTRL_CHAN_MSB:0] = chan + `CHAN_ONE; // see [RL2]
                        state_next = st_hold;
                    end
                    else
                    begin
                        // Single conversion: clear enable
                        converter_control_next[`CTRL_ENABLE_BIT] = 1'b0;
                        state_next = st_idle;
                    end
                end
            end
            st_hold:
            begin
                // Continuous in convert-on-read; stalls until DMA took the last result
                if (!enabled)
                    state_next = st_idle;
                else if (!result_valid_reg || dma_ack)
                begin
                    conv_start = 1'b1; // see [RL1]
                    state_next = st_convert;
                end
            end
            default: state_next = st_idle;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            converter_control_reg <= `CTRL_RESET;
            top_channel_limit_reg <= `TOP_RESET;
            start_channel_reg     <= 4'h0;
            result_reg            <= 10'h000;
            result_valid_reg      <= 1'b0;
            ack_reg               <= 1'b0;
            readdata_reg          <= `ZERO_WORD;
            state_reg             <= st_idle;
        end
        else
        begin
            converter_control_reg <= converter_control_next;
            top_channel_limit_reg <= top_channel_limit_next;
            start_channel_reg     <= start_channel_next;
            result_reg            <= result_next;
            result_valid_reg      <= result_valid_next;
            ack_reg               <= ack_next;
            readdata_reg          <= readdata_next;
            state_reg             <= state_next;
        end
    end

    assign avs_waitrequest     = (avs_read || avs_write) && !ack_reg;
    assign avs_readdata        = readdata_reg;
    assign analog_input_select = chan;
    // Single conversions leave the result for polling, so no request then
    assign dma_request         = result_valid_reg && cor_mode;
    assign conversion_result   = result_reg;
endmodule

/* hw/conv_timer.sv */
`timescale 1ns/100ps
`include "adc_scan_params.svh"
// Counts one conversion time after start, pulses done.
module conv_timer
    import adc_scan_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic start,
    output logic      busy,
    output logic      done
);
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic       done_next;

    always_comb
    begin
        count_next = count_reg;
        done_next  = 1'b0;
        if (count_reg != 8'h00)
        begin
            count_next = count_reg - 8'h01;
            done_next  = (count_reg == 8'h01);
        end
        else if (start)
            count_next = `CONV_CYCLES;
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            count_reg <= 8'h00;
            done      <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            done      <= done_next;
        end
    end

    assign busy = (count_reg != 8'h00);
endmodule

/* pkg/adc_scan_params.svh */
// Functional notes
// [RL1] Convert-on-read lets DMA take results, converts continuously
// [RL2] Channel advances by one per conversion
// [RL3] At limit, reload starting channel, not zero
// [RL4] Top-channel limit caps automatic channel increment
// [RL5] Software writes start channel before scanning
// [RL6] Software keeps limit at or above start
// [RL7] Start channel latched when scanning begins; the code latches it on every control-register write instead
`ifndef ADC_SCAN_PARAMS_SVH
`define ADC_SCAN_PARAMS_SVH
`define CTRL_OFFSET        4'h0
`define TOP_OFFSET         4'h4
`define RESULT_OFFSET      4'h8
`define STATUS_OFFSET      4'hc
`define CTRL_RESET         8'h00
`define TOP_RESET          8'h00
`define CTRL_ENABLE_BIT    7
`define CTRL_COR_BIT       6
`define CTRL_CHAN_MSB      3
`define CONV_CYCLES        8'h10
`define CHAN_ONE           4'h1
`define ZERO_WORD          32'h0000_0000
`endif

/* pkg/adc_scan_pkg.sv */
package adc_scan_pkg;
    typedef enum logic [2:0]
    {
        st_idle    = 3'b001,
        st_convert = 3'b010,
        st_hold    = 3'b100
    } scan_state_type;

    typedef struct packed
    {
        logic [3:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } bus_req_type;

    typedef struct packed
    {
        logic [31:0] readdata;
        logic        waitrequest;
    } bus_rsp_type;

    typedef struct packed
    {
        logic       valid;
        logic [9:0] data;
        logic [3:0] channel;
    } result_type;
endpackage
